// file: hdl/cswt_pkg.sv
// Purpose: constants and types of the cyclic sense / cyclic wake timers
// Assumes: clk_sys at 25 MHz, all timing derived from a 1 us tick
// Notes: timer setting code layout is period[2:0], on-time[5:3]
// How it works
// - timer runs as soon as on-time written
// - mapped output holds chosen OFF level before start
// - on-time longer than period flags config error
// - first sample is reference, change wakes
// - 16us stable filter after on-time end
// - each wake input sets its own flag
// - level status updates only in Normal or Stop
// - fail-safe disables outputs, inputs go static
// - faults disable output, timers keep running
// - Stop wake interrupts, Sleep wake restarts regulator
// - Sleep with pending flag wakes via Restart
// - enabled timer raises periodic interrupt once started
// - interrupt each on-time start except first
// - timers mappable to highside outputs by software
// - seven selectable periods per timer
// - five on-times plus OFF low and high
// - level change sampled at on-time end is potential wake
package cswt_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_HZ = 1_000_000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int FILTER_TIME_US = 16;
  localparam int FILTER_TICKS = FILTER_TIME_US * TICK_HZ / 1_000_000;
  localparam int RESTART_TIME_US = 100;
  localparam int RESTART_TICKS = RESTART_TIME_US * TICK_HZ / 1_000_000;
  localparam int CNT_W = 21;
  localparam int AW = 4;
  localparam int DW = 8;
  // register addresses
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_TMR1 = 4'h1;
  localparam logic [3:0] ADDR_TMR2 = 4'h2;
  localparam logic [3:0] ADDR_HSCTL = 4'h3;
  localparam logic [3:0] ADDR_WKCTL = 4'h4;
  localparam logic [3:0] ADDR_WKCFG = 4'h5;
  localparam logic [3:0] ADDR_WKST1 = 4'h6;
  localparam logic [3:0] ADDR_WKST2 = 4'h7;
  localparam logic [3:0] ADDR_CFGST = 4'h8;
  localparam logic [5:0] TMR_RESET = 6'h00;
  // on-time codes
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h1;
  // highside source codes
  localparam logic [1:0] HS_SRC_OFF = 2'h0;
  localparam logic [1:0] HS_SRC_ON = 2'h1;
  localparam logic [1:0] HS_SRC_T1 = 2'h2;
  // wake input sensing codes
  localparam logic [1:0] WK_STATIC = 2'h0;
  localparam logic [1:0] WK_CYC_T1 = 2'h1;
  localparam logic [1:0] WK_CYC_T2 = 2'h2;
  // mode commands
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_SLEEP = 2'h2;

  typedef enum logic [2:0] {
    CSWT_NORMAL = 3'b000,
    CSWT_STOP = 3'b001,
    CSWT_SLEEP = 3'b010,
    CSWT_RESTART = 3'b011,
    CSWT_FAILSAFE = 3'b100
  } cswt_mode_t;

  function automatic logic [CNT_W-1:0] cswt_period_us(logic [2:0] code);
    case (code)
      3'h0: cswt_period_us = 21'd10_000;
      3'h1: cswt_period_us = 21'd20_000;
      3'h2: cswt_period_us = 21'd50_000;
      3'h3: cswt_period_us = 21'd100_000;
      3'h4: cswt_period_us = 21'd200_000;
      3'h5: cswt_period_us = 21'd1_000_000;
      default: cswt_period_us = 21'd2_000_000;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] cswt_on_us(logic [2:0] code);
    case (code)
      3'h2: cswt_on_us = 21'd100;
      3'h3: cswt_on_us = 21'd300;
      3'h4: cswt_on_us = 21'd1_000;
      3'h5: cswt_on_us = 21'd10_000;
      3'h6: cswt_on_us = 21'd20_000;
      default: cswt_on_us = 21'd0;
    endcase
  endfunction
endpackage

// file: hdl/cswt_timer.sv
// Purpose: one periodic timer with on-time phase
// Assumes: tick is a one-cycle pulse once per microsecond
// Notes: onStart pulses only at wrap, never at the first on-time
`timescale 1ns/10ps
module cswt_timer
  import cswt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic load,
  input wire logic hold,
  input wire logic [5:0] setting,
  // state
  output logic running,
  output logic onPhase,
  output logic onStart,
  output logic onEnd,
  output logic cfgErr
);
  logic [CNT_W-1:0] cntQ, cntD, perUs, onUs;
  logic runQ, runD;

  assign perUs = cswt_period_us(setting[2:0]);
  assign onUs = cswt_on_us(setting[5:3]);

  always_comb begin
    cntD = cntQ;
    runD = runQ;
    if (load) begin
      cntD = '0;
      runD = setting[5:3] > ON_OFF_HIGH;
    end else if (hold) begin
      runD = 1'b0;
      cntD = '0;
    end else if (runQ && tick) begin
      if (cntQ == perUs - 21'd1) begin
        cntD = '0;
      end else begin
        cntD = cntQ + 21'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cntQ <= '0;
      runQ <= 1'b0;
    end else begin
      cntQ <= cntD;
      runQ <= runD;
    end
  end

  assign running = runQ;
  assign onPhase = runQ && (cntQ < onUs);
  // first on-time starts at load, so wraps are all later ones
  assign onStart = runQ && tick && (cntQ == perUs - 21'd1);
  assign onEnd = runQ && tick && (cntQ == onUs - 21'd1);
  assign cfgErr = runQ && (onUs > perUs);
endmodule

// file: hdl/cswt_top.sv
// Purpose: cyclic sense and cyclic wake with two timers
// Assumes: register port strobes one cycle, read data next cycle
// Notes: four highside outputs, three wake inputs, active low int/reset
`timescale 1ns/10ps
module cswt_top
  import cswt_pkg::*;
#(
  parameter int NUM_WK = 3,
  parameter int NUM_HS = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DW-1:0] regRdata,
  // wake inputs and highside outputs
  input wire logic [NUM_WK-1:0] wakeInput,
  output logic [NUM_HS-1:0] highsideOutput,
  // highside faults: overcurrent, overtemp, enabled supply fault
  input wire logic [NUM_HS-1:0] hsFault,
  // system
  input wire logic failSafeReq,
  output logic interruptOutputN,
  output logic mainRegulatorOutput,
  output logic resetOutN
);
  if (NUM_WK != 3 || NUM_HS != 4) begin : gBadCfg
    $error("cswt_top serves three wake inputs and four outputs");
  end

  // 1 us timebase
  logic [4:0] divQ, divD;
  logic tick;

  always_comb begin
    divD = divQ + 5'd1;
    if (divQ == 5'(TICK_CYCLES - 1)) begin
      divD = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divQ <= '0;
    end else begin
      divQ <= divD;
    end
  end

  assign tick = (divQ == 5'(TICK_CYCLES - 1));

  // registers and mode
  logic [5:0] tmr1Q, tmr1D, tmr2Q, tmr2D;
  logic [7:0] hsCtlQ, hsCtlD;
  logic [1:0] wkCtlQ, wkCtlD;
  logic [5:0] wkCfgQ, wkCfgD;
  logic [NUM_WK-1:0] wkFlagQ, wkFlagD, lvlStatQ, lvlStatD;
  logic [1:0] tmrFlagQ, tmrFlagD;
  logic cfgErrQ, cfgErrD;
  cswt_mode_t modeQ, modeD;
  logic [7:0] rstCntQ, rstCntD;
  logic [DW-1:0] rdataQ, rdataD;
  logic intNQ, intND, hsAllowed;
  logic wrMode, wrT1, wrT2, wrSt1, wrCfgSt;
  logic modeNS;

  // timers
  logic [1:0] tRun, tOn, tStart, tEnd, tErr;
  logic [5:0] tSet [2];
  logic [1:0] tLoad;
  logic tHold;

  // load must see the new code, not the one it replaces
  assign tSet[0] = tmr1D;
  assign tSet[1] = tmr2D;
  assign tLoad = {wrT2, wrT1};
  // cyclic operation stops in fail-safe
  assign tHold = (modeQ == CSWT_FAILSAFE);

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : gTmr
      cswt_timer uTmr (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .load(tLoad[t]),
        .hold(tHold),
        .setting(tSet[t]),
        .running(tRun[t]),
        .onPhase(tOn[t]),
        .onStart(tStart[t]),
        .onEnd(tEnd[t]),
        .cfgErr(tErr[t])
      );
    end
  endgenerate

  // wake input sensing, one filter per input
  logic [NUM_WK-1:0] wkEvent;
  genvar w;
  generate
    for (w = 0; w < NUM_WK; w++) begin : gWk
      logic [1:0] cfg;
      logic cyclic, trig, busyQ, busyD, candQ, candD;
      logic refQ, refD, refVldQ, refVldD;
      logic [4:0] fcQ, fcD;
      logic evD, evQ;
      assign cfg = wkCfgQ[2*w +: 2];
      // fail-safe forces static sensing
      assign cyclic = (modeQ != CSWT_FAILSAFE)
                      && (cfg == WK_CYC_T1 || cfg == WK_CYC_T2);
      // cyclic: sample at end of on-time; static: any change
      assign trig = cyclic
        ? tEnd[cfg == WK_CYC_T2]
        : (!busyQ && refVldQ && wakeInput[w] != refQ);

      always_comb begin
        busyD = busyQ;
        candD = candQ;
        refD = refQ;
        refVldD = refVldQ;
        fcD = fcQ;
        evD = 1'b0;
        if (!cyclic && !refVldQ) begin
          refD = wakeInput[w];
          refVldD = 1'b1;
        end else if (trig && !busyQ) begin
          busyD = 1'b1;
          candD = wakeInput[w];
          fcD = 5'(FILTER_TICKS);
        end else if (busyQ) begin
          if (wakeInput[w] != candQ) begin
            busyD = 1'b0;
          end else if (tick) begin
            fcD = fcQ - 5'd1;
            if (fcQ == 5'd1) begin
              busyD = 1'b0;
              refD = candQ;
              refVldD = 1'b1;
              evD = refVldQ && (candQ != refQ);
            end
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          busyQ <= 1'b0;
          candQ <= 1'b0;
          refQ <= 1'b0;
          refVldQ <= 1'b0;
          fcQ <= '0;
          evQ <= 1'b0;
        end else begin
          busyQ <= busyD;
          candQ <= candD;
          refQ <= refD;
          refVldQ <= refVldD;
          fcQ <= fcD;
          evQ <= evD;
        end
      end

      assign wkEvent[w] = evQ;

      always_comb begin
        lvlStatD[w] = lvlStatQ[w];
        if (busyQ && tick && fcQ == 5'd1 && wakeInput[w] == candQ
            && modeNS) begin
          lvlStatD[w] = candQ;
        end
      end
    end
  endgenerate

  assign modeNS = (modeQ == CSWT_NORMAL) || (modeQ == CSWT_STOP);
  assign wrMode = regWr && regAddr == ADDR_MODE;
  assign wrT1 = regWr && regAddr == ADDR_TMR1;
  assign wrT2 = regWr && regAddr == ADDR_TMR2;
  assign wrSt1 = regWr && regAddr == ADDR_WKST1;
  assign wrCfgSt = regWr && regAddr == ADDR_CFGST;

  always_comb begin
    tmr1D = tmr1Q;
    tmr2D = tmr2Q;
    hsCtlD = hsCtlQ;
    wkCtlD = wkCtlQ;
    wkCfgD = wkCfgQ;
    if (wrT1) begin
      tmr1D = regWdata[5:0];
    end else if (wrT2) begin
      tmr2D = regWdata[5:0];
    end else if (regWr && regAddr == ADDR_HSCTL) begin
      hsCtlD = regWdata;
    end else if (regWr && regAddr == ADDR_WKCTL) begin
      wkCtlD = regWdata[1:0];
    end else if (regWr && regAddr == ADDR_WKCFG) begin
      wkCfgD = regWdata[5:0];
    end
  end

  // flags: write one to clear, a same-cycle event wins
  always_comb begin
    wkFlagD = wkFlagQ;
    tmrFlagD = tmrFlagQ;
    cfgErrD = cfgErrQ;
    if (wrSt1) begin
      wkFlagD = wkFlagQ & ~regWdata[NUM_WK-1:0];
      tmrFlagD = tmrFlagQ & ~regWdata[4:3];
    end
    if (wrCfgSt) begin
      cfgErrD = cfgErrQ & ~regWdata[0];
    end
    wkFlagD = wkFlagD | wkEvent;
    // cyclic wake only counts in Normal and Stop
    tmrFlagD = tmrFlagD | (tStart & wkCtlQ & {2{modeNS}});
    cfgErrD = cfgErrD | (|tErr);
  end

  always_comb begin
    modeD = modeQ;
    rstCntD = rstCntQ;
    if (failSafeReq && modeQ != CSWT_FAILSAFE) begin
      modeD = CSWT_FAILSAFE;
    end else begin
      case (modeQ)
        CSWT_NORMAL, CSWT_STOP: begin
          if (wrMode && regWdata[1:0] == CMD_SLEEP) begin
            if (|wkFlagQ || |tmrFlagQ) begin
              modeD = CSWT_RESTART;
              rstCntD = '0;
            end else begin
              modeD = CSWT_SLEEP;
            end
          end else if (wrMode && regWdata[1:0] == CMD_STOP) begin
            modeD = CSWT_STOP;
          end else if (wrMode && regWdata[1:0] == CMD_NORMAL) begin
            modeD = CSWT_NORMAL;
          end
        end
        CSWT_SLEEP, CSWT_FAILSAFE: begin
          if (|wkEvent) begin
            modeD = CSWT_RESTART;
            rstCntD = '0;
          end
        end
        CSWT_RESTART: begin
          if (tick) begin
            rstCntD = rstCntQ + 8'd1;
            if (rstCntQ == 8'(RESTART_TICKS - 1)) begin
              modeD = CSWT_NORMAL;
            end
          end
        end
        default: modeD = CSWT_NORMAL;
      endcase
    end
  end

  // read mux and interrupt pin
  always_comb begin
    rdataD = '0;
    if (regRd) begin
      if (regAddr == ADDR_MODE) begin
        rdataD = {5'h00, modeQ};
      end else if (regAddr == ADDR_TMR1) begin
        rdataD = {2'h0, tmr1Q};
      end else if (regAddr == ADDR_TMR2) begin
        rdataD = {2'h0, tmr2Q};
      end else if (regAddr == ADDR_HSCTL) begin
        rdataD = hsCtlQ;
      end else if (regAddr == ADDR_WKCTL) begin
        rdataD = {tRun, 4'h0, wkCtlQ};
      end else if (regAddr == ADDR_WKCFG) begin
        rdataD = {2'h0, wkCfgQ};
      end else if (regAddr == ADDR_WKST1) begin
        rdataD = {3'h0, tmrFlagQ, wkFlagQ};
      end else if (regAddr == ADDR_WKST2) begin
        rdataD = {5'h00, lvlStatQ};
      end else if (regAddr == ADDR_CFGST) begin
        rdataD = {7'h00, cfgErrQ};
      end
    end
    // Stop wakes signal by interrupt, Sleep restarts instead
    intND = !(modeNS && (|wkFlagD || |tmrFlagD));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmr1Q <= TMR_RESET;
      tmr2Q <= TMR_RESET;
      hsCtlQ <= '0;
      wkCtlQ <= '0;
      wkCfgQ <= '0;
      wkFlagQ <= '0;
      lvlStatQ <= '0;
      tmrFlagQ <= '0;
      cfgErrQ <= 1'b0;
      modeQ <= CSWT_NORMAL;
      rstCntQ <= '0;
      rdataQ <= '0;
      intNQ <= 1'b1;
    end else begin
      tmr1Q <= tmr1D;
      tmr2Q <= tmr2D;
      hsCtlQ <= hsCtlD;
      wkCtlQ <= wkCtlD;
      wkCfgQ <= wkCfgD;
      wkFlagQ <= wkFlagD;
      lvlStatQ <= lvlStatD;
      tmrFlagQ <= tmrFlagD;
      cfgErrQ <= cfgErrD;
      modeQ <= modeD;
      rstCntQ <= rstCntD;
      rdataQ <= rdataD;
      intNQ <= intND;
    end
  end

  // highside drive
  logic [NUM_HS-1:0] hsQ, hsD;
  assign hsAllowed = (modeQ != CSWT_FAILSAFE);

  genvar h;
  generate
    for (h = 0; h < NUM_HS; h++) begin : gHs
      logic [1:0] src;
      logic tsel, tlvl;
      assign src = hsCtlQ[2*h +: 2];
      assign tsel = (src != HS_SRC_T1);
      // before start the pin sits at the chosen OFF level
      assign tlvl = tRun[tsel] ? tOn[tsel]
                  : (tSet[tsel][5:3] == ON_OFF_HIGH);
      always_comb begin
        hsD[h] = 1'b0;
        if (src == HS_SRC_ON) begin
          hsD[h] = 1'b1;
        end else if (src != HS_SRC_OFF) begin
          hsD[h] = tlvl;
        end
        // fault drops the pin only; the timer keeps going
        if (hsFault[h] || !hsAllowed) begin
          hsD[h] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hsQ <= '0;
    end else begin
      hsQ <= hsD;
    end
  end

  assign highsideOutput = hsQ;
  assign regRdata = rdataQ;
  assign interruptOutputN = intNQ;
  assign mainRegulatorOutput = (modeQ != CSWT_SLEEP)
                               && (modeQ != CSWT_FAILSAFE);
  assign resetOutN = (modeQ != CSWT_RESTART);
endmodule

// file: verification/cswt_switch_net.sv
// Purpose: switch network on the wake inputs, fed by one highside output
// Assumes: every wake line has a pull-down to ground
// Notes: open switch or unpowered supply reads low
`timescale 1ns/10ps
module cswt_switch_net (
  // supply and switches
  input wire logic supply,
  input wire logic [2:0] closed,
  // wake lines
  output logic [2:0] wake
);
  // pull-down wins whenever no current flows
  assign wake = supply ? closed : 3'h0;
endmodule

// file: verification/cswt_top_properties.sv
// Purpose: port-level properties of the cyclic timers block
// Assumes: one clock domain, synchronous active-high reset
// Notes: restart window allows slack for the tick phase
`timescale 1ns/10ps
module cswt_top_properties
  import cswt_pkg::*;
#(
  parameter int NUM_WK = 3,
  parameter int NUM_HS = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DW-1:0] regRdata,
  // pins
  input wire logic [NUM_WK-1:0] wakeInput,
  input wire logic [NUM_HS-1:0] highsideOutput,
  input wire logic [NUM_HS-1:0] hsFault,
  input wire logic failSafeReq,
  input wire logic interruptOutputN,
  input wire logic mainRegulatorOutput,
  input wire logic resetOutN
);
  logic [15:0] lowCnt_q;
  logic [15:0] lowCnt_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // counts cycles spent in restart
  always_comb begin
    lowCnt_d = resetOutN ? 16'h0000 : lowCnt_q + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    lowCnt_q <= rst ? 16'h0000 : lowCnt_d;
  end
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_read: assert property (
    $past(regRd) && $past(regAddr) > 4'h8 |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_fault_off: assert property (
    (highsideOutput & $past(hsFault) & $past(hsFault, 2)) == '0)
    else $error("highside on under fault");
  a_failsafe_off: assert property (
    failSafeReq |-> ##[1:3] (highsideOutput == '0 && !mainRegulatorOutput))
    else $error("fail-safe left outputs on");
  a_restart_supply: assert property (
    !resetOutN |-> mainRegulatorOutput)
    else $error("regulator off in restart");
  a_restart_len: assert property (
    $rose(resetOutN) |-> lowCnt_q >= 16'h09AB && lowCnt_q <= 16'h09F6)
    else $error("restart length wrong");
  a_sleep_int_quiet: assert property (
    !mainRegulatorOutput && !$past(mainRegulatorOutput) |-> interruptOutputN)
    else $error("interrupt low with regulator off");
  a_flag_int: assert property (
    $past(regRd) && $past(regAddr) == ADDR_WKST1 && regRdata[4:0] != 5'h00
    && $past(mainRegulatorOutput) && $past(resetOutN) |-> !interruptOutputN)
    else $error("flag set without interrupt");
endmodule

bind cswt_top cswt_top_properties #(.NUM_WK(NUM_WK), .NUM_HS(NUM_HS)) props (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .wakeInput(wakeInput), .highsideOutput(highsideOutput),
  .hsFault(hsFault), .failSafeReq(failSafeReq),
  .interruptOutputN(interruptOutputN),
  .mainRegulatorOutput(mainRegulatorOutput), .resetOutN(resetOutN));

// file: verification/testbench.sv
// Purpose: self-checking bench for the cyclic timers block
// Assumes: 40 ns clock, one-cycle register strobes
// Notes: periods of 10 ms exceed the run, only first on-times seen
`timescale 1ns/10ps
module testbench;
  import cswt_pkg::*;
  logic clk_sys, rst, regWr, regRd, failSafeReq;
  logic interruptOutputN, mainRegulatorOutput, resetOutN;
  logic [3:0] regAddr, highsideOutput, hsFault;
  logic [7:0] regWdata, regRdata;
  logic [2:0] wakeInput, sw, on, per;
  int mismatches, total_checks;
  integer seed;
  cswt_top uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .wakeInput(wakeInput),
    .highsideOutput(highsideOutput), .hsFault(hsFault),
    .failSafeReq(failSafeReq), .interruptOutputN(interruptOutputN),
    .mainRegulatorOutput(mainRegulatorOutput), .resetOutN(resetOutN));
  cswt_switch_net swNet (.supply(highsideOutput[3]), .closed(sw),
    .wake(wakeInput));
  function automatic int perUs(logic [2:0] c);
    int t[8] = '{10000, 20000, 50000, 100000, 200000, 1000000,
      2000000, 2000000};
    return t[c];
  endfunction
  function automatic int onUs(logic [2:0] c);
    int t[8] = '{0, 0, 100, 300, 1000, 10000, 20000, 0};
    return t[c];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [3:0] e);
    @(negedge clk_sys);
    chk({4'h0, highsideOutput}, {4'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m,
    input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    chk(regRdata & m, e);
  endtask
  task automatic waitHigh();
    for (int n = 0; n < 3000 && resetOutN !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    if (resetOutN !== 1'b1) begin
      mismatches++;
    end
    cyc(1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // whole run needs some 16k cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    results();
  end
  initial begin
    seed = 32'hE1FF6015;
    rst = 1'b1;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    hsFault = 4'h0;
    failSafeReq = 1'b0;
    sw = 3'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    pins(4'h0);
    chk({5'h0, interruptOutputN, mainRegulatorOutput, resetOutN}, 8'h07);
    rchk(ADDR_MODE, 8'h07, 8'h00);
    wr(4'hC, 8'h5A);
    rchk(4'hC, 8'hFF, 8'h00);
    wr(ADDR_TMR1, {2'b00, ON_OFF_HIGH, 3'h0});
    wr(ADDR_HSCTL, 8'h6A);
    wr(ADDR_WKCFG, 8'h00);
    cyc(2);
    pins(4'hF);
    wr(ADDR_TMR1, {2'b00, ON_OFF_LOW, 3'h0});
    cyc(2);
    pins(4'h8);
    rchk(ADDR_WKCTL, 8'h40, 8'h00);
    wr(ADDR_WKCTL, 8'h01);
    wr(ADDR_TMR1, 8'h10);
    cyc(2);
    pins(4'hF);
    rchk(ADDR_WKCTL, 8'h40, 8'h40);
    cyc(2600);
    pins(4'h8);
    rchk(ADDR_WKST1, 8'h18, 8'h00);
    chk({7'h0, interruptOutputN}, 8'h01);
    // every on code, random periods, then two boundary cases
    for (int k = 0; k < 10; k++) begin
      on = (k < 8) ? k[2:0] : ((k == 8) ? 3'h6 : 3'h5);
      per = (k < 8) ? 3'($random(seed)) : 3'h0;
      wr(ADDR_TMR2, {2'b00, on, per});
      rchk(ADDR_TMR2, 8'h3F, {2'b00, on, per});
      wr(ADDR_CFGST, 8'h01);
      cyc(3);
      rchk(ADDR_CFGST, 8'h01, {7'h0, onUs(on) > perUs(per)});
    end
    wr(ADDR_TMR2, 8'h00);
    wr(ADDR_TMR1, 8'h29);
    cyc(2);
    pins(4'hF);
    @(posedge clk_sys);
    hsFault <= 4'h2;
    cyc(3);
    pins(4'hD);
    @(posedge clk_sys);
    hsFault <= 4'h0;
    cyc(3);
    pins(4'hF);
    rchk(ADDR_WKCTL, 8'h40, 8'h40);
    cyc(700);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      sw[i] <= 1'b1;
      cyc(700);
      rchk(ADDR_WKST1, 8'h07, 8'h01 << i);
      chk({7'h0, interruptOutputN}, 8'h00);
      rchk(ADDR_WKST2, 8'h07, {5'h0, sw});
      wr(ADDR_WKST1, 8'h1F);
      cyc(2);
      chk({7'h0, interruptOutputN}, 8'h01);
    end
    // a glitch shorter than the filter must leave no flag
    @(posedge clk_sys);
    sw[0] <= 1'b0;
    cyc(1 + ($unsigned($random(seed)) % 350));
    @(posedge clk_sys);
    sw[0] <= 1'b1;
    cyc(700);
    rchk(ADDR_WKST1, 8'h07, 8'h00);
    @(posedge clk_sys);
    sw[0] <= 1'b0;
    cyc(700);
    wr(ADDR_MODE, {6'h00, CMD_SLEEP});
    rchk(ADDR_MODE, 8'h07, 8'h03);
    chk({7'h0, resetOutN}, 8'h00);
    waitHigh();
    rchk(ADDR_MODE, 8'h07, 8'h00);
    rchk(ADDR_WKST1, 8'h07, 8'h01);
    wr(ADDR_WKST1, 8'h1F);
    wr(ADDR_MODE, {6'h00, CMD_SLEEP});
    cyc(3);
    chk({7'h0, mainRegulatorOutput}, 8'h00);
    @(posedge clk_sys);
    sw[1] <= 1'b0;
    cyc(700);
    chk({6'h0, resetOutN, mainRegulatorOutput}, 8'h01);
    waitHigh();
    rchk(ADDR_WKST1, 8'h07, 8'h02);
    wr(ADDR_WKST1, 8'h1F);
    // input 0 sensed on timer1 on-times, armed before Stop
    wr(ADDR_WKCFG, {6'h00, WK_CYC_T1});
    wr(ADDR_TMR1, 8'h10);
    wr(ADDR_MODE, {6'h00, CMD_STOP});
    @(posedge clk_sys);
    sw[0] <= 1'b1;
    cyc(1000);
    rchk(ADDR_WKST1, 8'h07, 8'h00);
    cyc(2000);
    rchk(ADDR_WKST1, 8'h07, 8'h01);
    chk({7'h0, interruptOutputN}, 8'h00);
    rchk(ADDR_MODE, 8'h07, 8'h01);
    rchk(ADDR_WKST2, 8'h07, 8'h07);
    wr(ADDR_WKST1, 8'h1F);
    wr(ADDR_MODE, {6'h00, CMD_NORMAL});
    failSafeReq <= 1'b1;
    @(posedge clk_sys);
    failSafeReq <= 1'b0;
    cyc(3);
    pins(4'h0);
    rchk(ADDR_MODE, 8'h07, 8'h04);
    // released supply drops the closed inputs, sensed statically
    cyc(700);
    chk({7'h0, resetOutN}, 8'h00);
    results();
  end
endmodule
